// ### uhd_pkg.sv
// Summary of operation
// - Eleven-bit half-duplex characters: start, nine data, stop
// - Received character held in separate receive buffer
// - Transmit start aborts any reception in progress
// - Serial output driven inverted during transmission
// - Idle output follows port value; software keeps high
// - Baud divider gives eight ticks per bit
// - Three samples per bit, two-of-three majority
// - Ninth bit persists until written or received
// - Data write sends start, eight LSB-first, ninth, stop
// - Stop end releases pin, sets done, interrupts
// - Done flag cleared by zero write or data write
// - Writing one to done flag sets it
// - Idle receiver detects falling edge, skips start bit
// - Received ninth bit replaces stored ninth bit
// - After stop time, buffer loaded and full flag set
// - Each interrupt request gated by its own enable
// - Data address: write transmits, read returns buffer
// - Baud select picks divisor 6656 down to 208
// - Runs from processor clock, also during wait
// - Full flag set on buffer load; software writable
// - Baud select in control bits 3..1, immediate effect
// - Control bit 0 holds ninth bit
package uhd_pkg;

  // Register indices and byte addresses (index times four)
  localparam logic [9:0] UHD_DATA_IDX   = 10'h0d6;
  localparam logic [9:0] UHD_CTRL_IDX   = 10'h0d7;
  localparam logic [11:0] UHD_DATA_ADDR = {UHD_DATA_IDX, 2'b00};
  localparam logic [11:0] UHD_CTRL_ADDR = {UHD_CTRL_IDX, 2'b00};

  // Control register field positions
  localparam int UHD_CR_RX_FULL = 7;
  localparam int UHD_CR_TX_DONE = 6;
  localparam int UHD_CR_RX_IEN  = 5;
  localparam int UHD_CR_TX_IEN  = 4;
  localparam int UHD_CR_BAUD_HI = 3;
  localparam int UHD_CR_BAUD_LO = 1;
  localparam int UHD_CR_NINTH   = 0;

  // Values after reset
  localparam logic [7:0] UHD_CTRL_RESET = 8'h00;
  localparam logic [7:0] UHD_DATA_RESET = 8'h00;

  // Clock divisor per bit time, indexed by baud select; last code reserved
  localparam logic [12:0] UHD_BIT_DIV [8] = '{13'h1a00, 13'h0d00, 13'h0680, 13'h0340,
                                              13'h01a0, 13'h0100, 13'h00d0, 13'h0000};

  // Frame shape and sampling positions within the eight states
  localparam logic [2:0] UHD_LAST_STATE = 3'h7;
  localparam logic [3:0] UHD_TX_LAST    = 4'ha;
  localparam logic [3:0] UHD_RX_LAST    = 4'h8;
  localparam logic [2:0] UHD_SAMPLE_A   = 3'h2;
  localparam logic [2:0] UHD_SAMPLE_B   = 3'h3;
  localparam logic [2:0] UHD_SAMPLE_C   = 3'h4;

  // AXI responses
  localparam logic [1:0] UHD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UHD_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uhd_rx_state_t;

endpackage

// ### uhd_uart.sv
`timescale 1ns/1ns
module uhd_uart
  import uhd_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Serial line and shared port
  input  wire logic              serial_in_pin,
  input  wire logic              port_out_value,
  output logic                   serial_out_pin,
  output logic                   tx_output_select,
  // Interrupt requests
  output logic                   tx_irq,
  output logic                   rx_irq
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic              aw_full_q, w_full_q, aw_full_d, w_full_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane0_q;
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  logic              wr_go, wr_data, wr_ctrl, wr_hit;
  logic              rx_full_q, tx_done_q, rx_ien_q, tx_ien_q, ninth_q;
  logic [2:0]        baud_q;
  logic [7:0]        rx_buf_q;
  logic [9:0]        tick_cnt_q;
  logic [9:0]        tick_period;
  logic              tick_q, tick_restart;
  logic              tx_active_q, tx_finish;
  logic [10:0]       frame_q;
  logic [3:0]        tx_bit_q;
  logic [2:0]        tx_phase_q;
  logic              serial_out_q, tx_irq_q, rx_irq_q;
  logic              rx_s1_q, rx_s2_q, rx_s3_q, rx_fall;
  uhd_rx_state_t     rx_state_q;
  logic [2:0]        rx_phase_q;
  logic [3:0]        rx_bit_q;
  logic              samp_a_q, samp_b_q, rx_vote, rx_done;
  logic [8:0]        rx_shift_q;

  // Write channel holding state
  assign wr_go     = aw_full_q && w_full_q && !bvalid_q;
  assign aw_full_d = wr_go ? 1'b0 : (aw_full_q || (s_axi_awvalid && awready_q));
  assign w_full_d  = wr_go ? 1'b0 : (w_full_q || (s_axi_wvalid && wready_q));
  assign wr_hit    = (aw_addr_q == UHD_DATA_ADDR) || (aw_addr_q == UHD_CTRL_ADDR);
  assign wr_data   = wr_go && w_lane0_q && (aw_addr_q == UHD_DATA_ADDR);
  assign wr_ctrl   = wr_go && w_lane0_q && (aw_addr_q == UHD_CTRL_ADDR);

  // Address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= UHD_DATA_RESET;
      w_lane0_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= !aw_full_d;
      wready_q  <= !w_full_d;
      if (s_axi_awvalid && awready_q) begin
        aw_addr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && wready_q) begin
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
    end
  end

  // Write response, error on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= UHD_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? UHD_RESP_OKAY : UHD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel; reads have no side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= UHD_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= UHD_RESP_OKAY;
      if ({s_axi_araddr[ADDR_W-1:2], 2'b00} == UHD_DATA_ADDR) begin
        rdata_q <= {24'h000000, rx_buf_q};
      end else if ({s_axi_araddr[ADDR_W-1:2], 2'b00} == UHD_CTRL_ADDR) begin
        rdata_q <= {24'h000000, rx_full_q, tx_done_q, rx_ien_q, tx_ien_q,
                    baud_q, ninth_q};
      end else begin
        rdata_q <= '0;
        rresp_q <= UHD_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // Enables and baud select, live immediately
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ien_q <= UHD_CTRL_RESET[UHD_CR_RX_IEN];
      tx_ien_q <= UHD_CTRL_RESET[UHD_CR_TX_IEN];
      baud_q   <= UHD_CTRL_RESET[UHD_CR_BAUD_HI:UHD_CR_BAUD_LO];
    end else if (wr_ctrl) begin
      rx_ien_q <= w_data_q[UHD_CR_RX_IEN];
      tx_ien_q <= w_data_q[UHD_CR_TX_IEN];
      baud_q   <= w_data_q[UHD_CR_BAUD_HI:UHD_CR_BAUD_LO];
    end
  end

  // Ninth bit: received value wins over a same-cycle write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ninth_q <= UHD_CTRL_RESET[UHD_CR_NINTH];
    end else if (rx_done) begin
      ninth_q <= rx_shift_q[8];
    end else if (wr_ctrl) begin
      ninth_q <= w_data_q[UHD_CR_NINTH];
    end
  end

  // Transmit done flag; hardware set wins over a control write, a same-cycle data write clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_done_q <= UHD_CTRL_RESET[UHD_CR_TX_DONE];
    end else if (tx_finish) begin
      tx_done_q <= 1'b1;
    end else if (wr_data) begin
      tx_done_q <= 1'b0;
    end else if (wr_ctrl) begin
      tx_done_q <= w_data_q[UHD_CR_TX_DONE];
    end
  end

  // Receive full flag; hardware set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_q <= UHD_CTRL_RESET[UHD_CR_RX_FULL];
    end else if (rx_done) begin
      rx_full_q <= 1'b1;
    end else if (wr_ctrl) begin
      rx_full_q <= w_data_q[UHD_CR_RX_FULL];
    end
  end

  // Eight-times baud tick from the processor clock
  assign tick_period  = UHD_BIT_DIV[baud_q][12:3];
  assign tick_restart = wr_data || rx_fall;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_restart || tick_period == 10'h000) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= tick_period - 10'h001) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 10'h001;
      tick_q     <= 1'b0;
    end
  end

  // Transmit shifter: start, eight data LSB first, ninth, stop
  assign tx_finish = tx_active_q && tick_q && !wr_data &&
                     tx_phase_q == UHD_LAST_STATE && tx_bit_q == UHD_TX_LAST;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_active_q <= 1'b0;
      frame_q     <= '1;
      tx_bit_q    <= '0;
      tx_phase_q  <= '0;
    end else if (wr_data) begin
      tx_active_q <= 1'b1;
      frame_q     <= {1'b1, ninth_q, w_data_q, 1'b0};
      tx_bit_q    <= '0;
      tx_phase_q  <= '0;
    end else if (tx_active_q && tick_q) begin
      tx_phase_q <= tx_phase_q + 3'h1;
      if (tx_phase_q == UHD_LAST_STATE) begin
        if (tx_bit_q == UHD_TX_LAST) begin
          tx_active_q <= 1'b0;
        end else begin
          frame_q  <= {1'b1, frame_q[10:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
        end
      end
    end
  end

  // Output mux: inverted frame while sending, port value otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out_q <= 1'b0;
    end else if (tx_active_q) begin
      serial_out_q <= ~frame_q[0];
    end else begin
      serial_out_q <= port_out_value;
    end
  end

  // Interrupt requests gated by enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
    end else begin
      tx_irq_q <= tx_done_q && tx_ien_q;
      rx_irq_q <= rx_full_q && rx_ien_q;
    end
  end

  // Receive input synchroniser and edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= serial_in_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // Falling edge only while idle and not sending
  assign rx_fall = rx_state_q == RX_IDLE && !tx_active_q && !wr_data &&
                   rx_s3_q && !rx_s2_q;
  assign rx_vote = (samp_a_q & samp_b_q) | (samp_a_q & rx_s2_q) |
                   (samp_b_q & rx_s2_q);
  assign rx_done = rx_state_q == RX_STOP && tick_q && rx_phase_q == UHD_LAST_STATE &&
                   !wr_data;

  // Receive sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_q <= RX_IDLE;
      rx_phase_q <= '0;
      rx_bit_q   <= '0;
      samp_a_q   <= 1'b0;
      samp_b_q   <= 1'b0;
      rx_shift_q <= '0;
    end else if (wr_data || tx_active_q) begin
      rx_state_q <= RX_IDLE;
    end else begin
      if (tick_q) begin
        rx_phase_q <= rx_phase_q + 3'h1;
      end
      case (rx_state_q)
        RX_IDLE: begin
          if (rx_fall) begin
            rx_state_q <= RX_START;
            rx_phase_q <= '0;
          end
        end
        RX_START: begin
          if (tick_q && rx_phase_q == UHD_LAST_STATE) begin
            rx_state_q <= RX_DATA;
            rx_bit_q   <= '0;
          end
        end
        RX_DATA: begin
          if (tick_q && rx_phase_q == UHD_SAMPLE_A) begin
            samp_a_q <= rx_s2_q;
          end
          if (tick_q && rx_phase_q == UHD_SAMPLE_B) begin
            samp_b_q <= rx_s2_q;
          end
          if (tick_q && rx_phase_q == UHD_SAMPLE_C) begin
            rx_shift_q <= {rx_vote, rx_shift_q[8:1]};
          end
          if (tick_q && rx_phase_q == UHD_LAST_STATE) begin
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == UHD_RX_LAST) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_done) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer apart from the shifter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_q <= UHD_DATA_RESET;
    end else if (rx_done) begin
      rx_buf_q <= rx_shift_q[7:0];
    end
  end

  // Port outputs
  assign s_axi_awready    = awready_q;
  assign s_axi_wready     = wready_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rdata      = rdata_q;
  assign s_axi_rresp      = rresp_q;
  assign serial_out_pin   = serial_out_q;
  assign tx_output_select = tx_active_q;
  assign tx_irq           = tx_irq_q;
  assign rx_irq           = rx_irq_q;

  // Checks on the serial engine
  a_tx_start_bit: assert property (wr_data |=> tx_active_q ##1 serial_out_q)
    else $error("start bit not driven after data write");
  a_done_at_end: assert property ($fell(tx_active_q) |-> tx_done_q)
    else $error("done flag not set at end of frame");
  a_done_cleared: assert property (wr_data |=> !tx_done_q)
    else $error("done flag not cleared by data write");
  a_sw_set_done: assert property (wr_ctrl && w_data_q[UHD_CR_TX_DONE] |=> tx_done_q)
    else $error("software set of done flag lost");
  a_abort_rx: assert property (wr_data |=> rx_state_q == RX_IDLE)
    else $error("reception not aborted by transmit");
  a_full_on_load: assert property (rx_done |=>
                                   rx_full_q && rx_buf_q == $past(rx_shift_q[7:0]))
    else $error("buffer load did not set full flag");
  a_buffer_hold: assert property (!rx_done |=> $stable(rx_buf_q))
    else $error("receive buffer changed without a character");
  a_ninth_keep: assert property (!wr_ctrl && !rx_done |=> $stable(ninth_q))
    else $error("ninth bit changed without cause");
  a_tick_space: assert property (tick_q && baud_q == 3'h6 && !tick_restart |=>
                                 !tick_q [*8])
    else $error("baud ticks too close");
  a_irq_gate: assert property (tx_irq_q |-> $past(tx_done_q) && $past(tx_ien_q))
    else $error("transmit request without enabled flag");
  a_idle_port: assert property (aresetn && !tx_active_q ##1 !tx_active_q |->
                                serial_out_q == $past(port_out_value))
    else $error("idle output not following port");

  c_tx_frame: cover property ($fell(tx_active_q));
  c_rx_char: cover property (rx_done);
  c_rx_abort: cover property (rx_state_q == RX_DATA ##1 wr_data);
  c_sw_irq: cover property (wr_ctrl && w_data_q[UHD_CR_TX_DONE] && tx_ien_q);

endmodule

// ### uhd_remote.sv
`timescale 1ns/1ns
module uhd_remote (
  // Clock
  input  wire logic aclk,
  // Device side of the shared pins
  input  wire logic serial_out_pin,
  input  wire logic tx_output_select,
  // Line into the device, pulled up when idle
  output logic      line_q
);
  logic [8:0] got;
  int         n_got     = 0;
  int         frame_err = 0;
  int         bit_clk   = 208;

  // Idle line rests at the stop level
  initial line_q = 1'b1;

  // One start, nine data LSB first, one stop
  task automatic send(input logic [8:0] w);
    for (int b = 0; b < 11; b++) begin
      line_q <= (b == 0) ? 1'b0 : (b == 10) ? 1'b1 : w[b-1];
      repeat (bit_clk) @(posedge aclk);
    end
    line_q <= 1'b1;
  endtask

  // Mid-bit sampling of the inverted output while the device owns it
  always begin
    @(posedge tx_output_select);
    for (int b = 0; b < 11; b++) begin
      repeat (b ? bit_clk : bit_clk / 2) @(posedge aclk);
      if (b >= 1 && b <= 9) got[b-1] = ~serial_out_pin;
      else if (~serial_out_pin !== (b == 10)) frame_err++;
    end
    n_got++;
  end
endmodule

// ### tb.sv
`timescale 1ns/1ns
module tb;
  import uhd_pkg::*;
  // Bus drivers and port value
  logic        aclk           = 1'b0;
  logic        aresetn        = 1'b0;
  logic [11:0] s_axi_awaddr   = 12'h000;
  logic        s_axi_awvalid  = 1'b0;
  logic [31:0] s_axi_wdata    = 32'h0;
  logic        s_axi_wvalid   = 1'b0;
  logic [3:0]  s_axi_wstrb    = 4'hf;
  logic [2:0]  s_axi_awprot   = 3'h0;
  logic [2:0]  s_axi_arprot   = 3'h0;
  logic        s_axi_bready   = 1'b0;
  logic [11:0] s_axi_araddr   = 12'h000;
  logic        s_axi_arvalid  = 1'b0;
  logic        s_axi_rready   = 1'b0;
  logic        port_out_value = 1'b1; // Software keeps the idle level high
  // Design outputs and bench state
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic        serial_in_pin, serial_out_pin, tx_output_select, tx_irq, rx_irq;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          n;
  // Parity row computed by software
  logic [8:0]  rows [4]  = '{9'h000, 9'h1ff, 9'h0a5, {^8'h6b, 8'h6b}};
  logic [9:0]  irq_rows [5] = '{{8'h5c, 2'b10}, {8'h4c, 2'b00}, {8'hac, 2'b01},
                                {8'h8c, 2'b00}, {8'h2c, 2'b00}};
  int          div [7]   = '{6656, 3328, 1664, 832, 416, 256, 208};

  // Clock
  always #5 aclk = ~aclk;

  uhd_uart uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .serial_in_pin(serial_in_pin),
    .port_out_value(port_out_value), .serial_out_pin(serial_out_pin),
    .tx_output_select(tx_output_select), .tx_irq(tx_irq), .rx_irq(rx_irq));

  uhd_remote u_rem (.aclk(aclk), .serial_out_pin(serial_out_pin),
    .tx_output_select(tx_output_select), .line_q(serial_in_pin));

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Whole-word write, never read-modify-write on data
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Register read
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Bounded wait on the output select
  task automatic wait_sel(input logic v);
    for (int i = 0; i < 5000 && tx_output_select !== v; i++) @(posedge aclk);
  endtask

  // Verdict
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (80000) @(posedge aclk);
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("reset_out", 32'({tx_output_select, tx_irq, rx_irq}), 0);
    rd_reg(UHD_CTRL_ADDR, rd);
    check("reset_ctrl", rd, 0);
    // Transmit rows
    foreach (rows[i]) begin
      wr(UHD_CTRL_ADDR, {4'h5, 3'h6, rows[i][8]});
      n = u_rem.n_got;
      wr(UHD_DATA_ADDR, rows[i][7:0]);
      rd_reg(UHD_CTRL_ADDR, rd);
      check("done_clear", 32'(rd[6]), 0);
      wait_sel(1'b0);
      repeat (2) @(posedge aclk);
      check("frames", 32'(u_rem.n_got - n), 1);
      check("tx_word", 32'(u_rem.got), 32'(rows[i]));
      check("tx_irq", 32'(tx_irq), 1);
      rd_reg(UHD_CTRL_ADDR, rd);
      check("ctrl_done", rd, {24'h0, 4'h5, 3'h6, rows[i][8]});
    end
    check("frame_err", 32'(u_rem.frame_err), 0);
    // Ninth bit kept from the previous frame
    wr(UHD_DATA_ADDR, 8'h33);
    wait_sel(1'b0);
    repeat (2) @(posedge aclk);
    check("ninth_kept", 32'(u_rem.got), {23'h0, rows[3][8], 8'h33});
    // Flag writes and interrupt gating
    foreach (irq_rows[i]) begin
      wr(UHD_CTRL_ADDR, irq_rows[i][9:2]);
      repeat (2) @(posedge aclk);
      check("irqs", 32'({tx_irq, rx_irq}), 32'(irq_rows[i][1:0]));
    end
    // Reception into the buffer
    u_rem.send(9'h1c3);
    repeat (300) @(posedge aclk);
    check("rx_irq", 32'(rx_irq), 1);
    rd_reg(UHD_CTRL_ADDR, rd);
    check("rx_ctrl", rd, 32'had);
    rd_reg(UHD_DATA_ADDR, rd);
    check("rx_data", rd, 32'hc3);
    fork
      u_rem.send(9'h05a);
      begin
        repeat (1000) @(posedge aclk);
        rd_reg(UHD_DATA_ADDR, rd);
        check("rx_hold", rd, 32'hc3);
      end
    join
    repeat (300) @(posedge aclk);
    rd_reg(UHD_DATA_ADDR, rd);
    check("rx_next", rd, 32'h5a);
    rd_reg(UHD_CTRL_ADDR, rd);
    check("rx_ninth", rd, 32'hac);
    // Transmit start in mid-reception
    wr(UHD_CTRL_ADDR, 8'h0c);
    fork
      u_rem.send(9'h1ff);
      begin
        repeat (600) @(posedge aclk);
        wr(UHD_DATA_ADDR, 8'h81);
      end
    join
    wait_sel(1'b0);
    repeat (300) @(posedge aclk);
    check("abort_word", 32'(u_rem.got), 32'h081);
    rd_reg(UHD_CTRL_ADDR, rd);
    check("abort_ctrl", rd, 32'h4c);
    // Idle pin follows port value
    port_out_value <= 1'b0;
    repeat (3) @(posedge aclk);
    check("idle_low", 32'(serial_out_pin), 0);
    port_out_value <= 1'b1;
    repeat (3) @(posedge aclk);
    check("idle_high", 32'(serial_out_pin), 1);
    // Unmapped address
    wr(12'h000, 8'h00);
    check("wr_unmapped", 32'(resp), 32'(UHD_RESP_SLVERR));
    rd_reg(12'h004, rd);
    check("rd_unmapped", {rd[29:0], resp}, 32'(UHD_RESP_SLVERR));
    // Cleared lane 0 makes a mapped write a no-op; protection bits ignored
    s_axi_awprot <= 3'h7;
    s_axi_arprot <= 3'h7;
    s_axi_wstrb  <= 4'h0;
    wr(UHD_CTRL_ADDR, 8'hff);
    s_axi_wstrb  <= 4'hf;
    check("wr_no_lane", 32'(resp), 32'(UHD_RESP_OKAY));
    rd_reg(UHD_CTRL_ADDR, rd);
    check("ctrl_unchanged", rd, 32'h4c);
    // Start bit length for baud codes 0 to 6 (not the reserved code 7), then reset mid-frame
    for (int c = 0; c < 7; c++) begin
      wr(UHD_CTRL_ADDR, {4'h0, 3'(c), 1'b0});
      wr(UHD_DATA_ADDR, 8'hff);
      n = 0;
      while (serial_out_pin === 1'b1 && n < 8000) begin
        @(posedge aclk);
        n++;
      end
      check("bit_time", 32'(n >= div[c] - 3 && n <= div[c] + 2), 1);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      check("reset_abort", 32'({tx_output_select, tx_irq}), 0);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
    end
    stop_test();
  end
endmodule
